// ===== lbcs_pkg.sv
// Package with constants and types of the local bus cycle sequencer.
package lbcs_pkg;

  // Cycle status codes driven on bus_cycle_status.
  localparam logic [2:0] LBCS_ST_INTA   = 3'h0;
  localparam logic [2:0] LBCS_ST_IO_RD  = 3'h1;
  localparam logic [2:0] LBCS_ST_IO_WR  = 3'h2;
  localparam logic [2:0] LBCS_ST_HALT   = 3'h3;
  localparam logic [2:0] LBCS_ST_FETCH  = 3'h4;
  localparam logic [2:0] LBCS_ST_MEM_RD = 3'h5;
  localparam logic [2:0] LBCS_ST_MEM_WR = 3'h6;
  localparam logic [2:0] LBCS_ST_IDLE   = 3'h7;

  // Bus geometry.
  localparam int LBCS_DATA_W  = 16;
  localparam int LBCS_ADDR_W  = 20;
  localparam int LBCS_ADDR_HI = 16;
  localparam int LBCS_FIFO_DEPTH = 32;

  // Input clock period, and input clocks per period of the output timing reference.
  localparam int LBCS_CLK_PERIOD_NS = 20;
  localparam int LBCS_REF_DIV       = 2;
  localparam int LBCS_REF_PERIOD_NS = LBCS_CLK_PERIOD_NS * LBCS_REF_DIV;

  // Values after reset.
  localparam logic                   LBCS_PHASE_RST = 1'b0;
  localparam logic [LBCS_DATA_W-1:0] LBCS_DATA_RST  = 16'h0000;
  localparam logic [LBCS_ADDR_W-1:0] LBCS_ADDR_RST  = 20'h00000;
  localparam logic [3:0]             LBCS_AHI_RST   = 4'h0;

  // Bus cycle phases, each lasting whole output clock periods; T1, T2 and T4 last one, T3 one more per wait.
  typedef enum logic [2:0] {
    LBCS_IDLE,
    LBCS_T1,
    LBCS_T2,
    LBCS_T3,
    LBCS_T4,
    LBCS_HOLD
  } lbcs_state_t;

endpackage

// ===== lbcs_fifo.sv
// First-word-fall-through FIFO with registered read data.
`timescale 1ns/10ps
module lbcs_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  // Clock and reset.
  input  wire logic             clock,
  input  wire logic             srst,
  // Filling side.
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Draining side.
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW-1:0]    rd_ptr_next;
  logic [AW:0]      count_reg;
  logic [AW:0]      count_next;
  logic [WIDTH-1:0] out_data_reg;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;
  wire              bypass = push && (wr_ptr_reg == rd_ptr_next);

  assign in_ready    = (count_reg != (AW+1)'(DEPTH));
  assign out_valid   = (count_reg != '0);
  assign out_data    = out_data_reg;
  assign rd_ptr_next = pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
  assign count_next  = count_reg + (AW+1)'(push) - (AW+1)'(pop);

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  // The output register looks one word ahead so that a pop sees fresh data next cycle.
  always_ff @(posedge clock) begin
    if (srst) begin
      wr_ptr_reg   <= '0;
      rd_ptr_reg   <= '0;
      count_reg    <= '0;
      out_data_reg <= '0;
    end else begin
      wr_ptr_reg   <= push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
      rd_ptr_reg   <= rd_ptr_next;
      count_reg    <= count_next;
      out_data_reg <= bypass ? in_data : mem[rd_ptr_next];
    end
  end
endmodule

// ===== lbcs_bus_master.sv
// Local bus cycle sequencer: status, address latch, strobes, ready and transceiver control.
//
// Behaviour
// [R1] The status pins carry 000 inta, 001 io read, 010 io write, 011 halt, 100 fetch, 101 mem read, 110 mem write, 111 idle.
// [R2] A one-clock address latch pulse is given in the address phase of every cycle.
// [R3] Upper byte enable is active whenever the cycle moves data on the upper data byte.
// [R4] On the wide bus, low address bit and upper enable encode word, even byte, odd byte and refresh.
// [R5] On the narrow bus the upper enable pin becomes a refresh indicator, low in refresh cycles.
// [R6] While the read strobe is low the addressed device drives the data bus and the block captures it.
// [R7] While the write strobe is low the block holds write data on the bus for the device to store.
// [R8] The external device asserts ready to end a cycle, and the cycle stays open until it does.
// [R9] A cycle flagged to ignore ready ends without waiting for it.
// [R10] The transceiver enable is active only in the data phase, never in the address phase.
// [R11] The status pins show the type of the cycle being started.
// [R12] The output timing reference runs at half the input clock with even duty, and all signalling follows it.
// [R13] During a hold grant the data bus and bus control outputs are floated.
// [R14] Address and status come first, strobes in the data phase, and status returns to idle after the cycle.
// [R15] Ready is sampled once per output clock period in the data phase, each inactive sample adding one wait.
`timescale 1ns/10ps
module lbcs_bus_master #(
  parameter bit NARROW_BUS = 1'b0
) (
  // Clock and reset.
  input  wire logic                             clock,
  input  wire logic                             srst,
  // Cycle requests.
  input  wire logic                             req_valid,
  output logic                                  req_ready,
  input  wire logic [2:0]                       req_status,
  input  wire logic [lbcs_pkg::LBCS_ADDR_W-1:0] req_addr,
  input  wire logic [lbcs_pkg::LBCS_DATA_W-1:0] req_wdata,
  input  wire logic                             req_word,
  input  wire logic                             req_refresh,
  input  wire logic                             req_no_wait,
  // Read data.
  output logic                                  rd_valid,
  input  wire logic                             rd_ready,
  output logic [lbcs_pkg::LBCS_DATA_W-1:0]      rd_data,
  // Bus pins.
  output logic                                  output_timing_reference,
  output logic [2:0]                            bus_cycle_status,
  output logic                                  ale,
  output logic                                  upper_byte_enable_n,
  output logic                                  rd_strobe_n,
  output logic                                  wr_strobe_n,
  output logic                                  transceiver_enable_n,
  output logic [3:0]                            addr_hi,
  output logic [lbcs_pkg::LBCS_DATA_W-1:0]      ad_out,
  output logic                                  ad_oe,
  input  wire logic [lbcs_pkg::LBCS_DATA_W-1:0] ad_in,
  output logic                                  ctrl_oe,
  input  wire logic                             ready_pin,
  input  wire logic                             hold_request,
  output logic                                  bus_release_grant
);
  import lbcs_pkg::*;

  lbcs_state_t            state_reg;
  lbcs_state_t            state_next;
  logic                   phase_reg;
  logic                   ready_s1_reg;
  logic                   ready_s2_reg;
  logic                   hold_s1_reg;
  logic                   hold_s2_reg;
  logic [LBCS_DATA_W-1:0] ad_s1_reg;
  logic [LBCS_DATA_W-1:0] ad_s2_reg;
  logic [2:0]             status_reg;
  logic [LBCS_ADDR_W-1:0] addr_reg;
  logic [LBCS_DATA_W-1:0] wdata_reg;
  logic                   word_reg;
  logic                   refresh_reg;
  logic                   nowait_reg;
  logic                   fifo_in_ready;

  // Every transition falls on the second half of an output clock period.
  wire period_end = phase_reg;
  wire accept     = req_valid && req_ready;
  wire ready_seen = ready_s2_reg || nowait_reg;

  assign req_ready = (state_reg == LBCS_IDLE) && period_end && !hold_s2_reg && fifo_in_ready;

  // The new request steers the pins in the same edge that opens its address phase.
  wire [2:0]             cur_status  = accept ? req_status  : status_reg;
  wire [LBCS_ADDR_W-1:0] cur_addr    = accept ? req_addr    : addr_reg;
  wire [LBCS_DATA_W-1:0] cur_wdata   = accept ? req_wdata   : wdata_reg;
  wire                   cur_word    = accept ? req_word    : word_reg;
  wire                   cur_refresh = accept ? req_refresh : refresh_reg;

  wire cur_write = (cur_status == LBCS_ST_IO_WR) || (cur_status == LBCS_ST_MEM_WR);
  wire cur_read  = (cur_status == LBCS_ST_INTA) || (cur_status == LBCS_ST_IO_RD) ||
                   (cur_status == LBCS_ST_FETCH) || (cur_status == LBCS_ST_MEM_RD);
  wire reg_read  = (status_reg == LBCS_ST_INTA) || (status_reg == LBCS_ST_IO_RD) ||
                   (status_reg == LBCS_ST_FETCH) || (status_reg == LBCS_ST_MEM_RD);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      LBCS_IDLE: begin
        if (period_end && hold_s2_reg) begin
          state_next = LBCS_HOLD;
        end else if (accept) begin
          state_next = LBCS_T1;
        end
      end
      LBCS_T1: begin
        if (period_end) begin
          state_next = LBCS_T2;
        end
      end
      LBCS_T2: begin
        if (period_end) begin
          state_next = LBCS_T3;
        end
      end
      LBCS_T3: begin
        if (period_end && ready_seen) begin // R8 R9 R15
          state_next = LBCS_T4;
        end
      end
      LBCS_T4: begin
        if (period_end) begin
          state_next = LBCS_IDLE;
        end
      end
      LBCS_HOLD: begin
        if (period_end && !hold_s2_reg) begin
          state_next = LBCS_IDLE;
        end
      end
      default: state_next = LBCS_IDLE;
    endcase
  end

  // Pin values for the coming clock, decoded from the next state and phase.
  wire ns_addr   = (state_next == LBCS_T1);
  wire ns_data   = (state_next == LBCS_T2) || (state_next == LBCS_T3);
  wire ns_active = ns_addr || ns_data;
  wire ns_hold   = (state_next == LBCS_HOLD);

  wire       lowest_address_bit = cur_refresh || (cur_addr[0] && !cur_word); // R4
  wire       wide_ube_n         = cur_refresh || !(cur_word || lowest_address_bit); // R3 R4
  wire       refresh_indicator_n = !cur_refresh; // R5
  wire       ube_pin_n  = NARROW_BUS ? refresh_indicator_n : wide_ube_n;
  wire [2:0] status_nx  = ns_active ? cur_status : LBCS_ST_IDLE; // R1 R11 R14
  wire       ale_nx     = ns_addr && phase_reg; // R2
  wire       rd_nx_n    = !(ns_data && cur_read); // R6 R14
  wire       wr_nx_n    = !(ns_data && cur_write); // R7 R14
  wire       xcvr_nx_n  = !(ns_data && (cur_read || cur_write)); // R10
  wire       ad_oe_nx   = ns_addr || (ns_data && cur_write); // R7 R13
  wire [LBCS_DATA_W-1:0] ad_nx =
    ns_addr ? {cur_addr[LBCS_DATA_W-1:1], lowest_address_bit} : cur_wdata;
  wire [3:0] ahi_nx = ns_addr ? cur_addr[LBCS_ADDR_W-1:LBCS_ADDR_HI] : LBCS_AHI_RST;

  // Read data sampled through the synchroniser at the close of the last period.
  wire push = (state_reg == LBCS_T4) && period_end && reg_read; // R6

  // Pin inputs are asynchronous to this clock, so each passes two flops first.
  always_ff @(posedge clock) begin
    if (srst) begin
      ready_s1_reg <= 1'b0;
      ready_s2_reg <= 1'b0;
      hold_s1_reg  <= 1'b0;
      hold_s2_reg  <= 1'b0;
      ad_s1_reg    <= LBCS_DATA_RST;
      ad_s2_reg    <= LBCS_DATA_RST;
    end else begin
      ready_s1_reg <= ready_pin;
      ready_s2_reg <= ready_s1_reg;
      hold_s1_reg  <= hold_request;
      hold_s2_reg  <= hold_s1_reg;
      ad_s1_reg    <= ad_in;
      ad_s2_reg    <= ad_s1_reg;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state_reg <= LBCS_IDLE;
      phase_reg <= LBCS_PHASE_RST;
    end else begin
      state_reg <= state_next;
      phase_reg <= !phase_reg; // R12
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      status_reg  <= LBCS_ST_IDLE;
      addr_reg    <= LBCS_ADDR_RST;
      wdata_reg   <= LBCS_DATA_RST;
      word_reg    <= 1'b0;
      refresh_reg <= 1'b0;
      nowait_reg  <= 1'b0;
    end else if (accept) begin
      status_reg  <= req_status;
      addr_reg    <= req_addr;
      wdata_reg   <= req_wdata;
      word_reg    <= req_word;
      refresh_reg <= req_refresh;
      nowait_reg  <= req_no_wait;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      bus_cycle_status     <= LBCS_ST_IDLE;
      ale                  <= 1'b0;
      upper_byte_enable_n  <= 1'b1;
      rd_strobe_n          <= 1'b1;
      wr_strobe_n          <= 1'b1;
      transceiver_enable_n <= 1'b1;
      addr_hi              <= LBCS_AHI_RST;
      ad_out               <= LBCS_DATA_RST;
      ad_oe                <= 1'b0;
      ctrl_oe              <= 1'b1;
      bus_release_grant    <= 1'b0;
    end else begin
      bus_cycle_status     <= status_nx;
      ale                  <= ale_nx;
      upper_byte_enable_n  <= ns_active ? ube_pin_n : 1'b1;
      rd_strobe_n          <= rd_nx_n;
      wr_strobe_n          <= wr_nx_n;
      transceiver_enable_n <= xcvr_nx_n;
      addr_hi              <= ahi_nx;
      ad_out               <= ad_nx;
      ad_oe                <= ad_oe_nx && !ns_hold;
      ctrl_oe              <= !ns_hold; // R13
      bus_release_grant    <= ns_hold;
    end
  end

  assign output_timing_reference = phase_reg;

  // The sequencer only starts a cycle while the FIFO has room, so a push is never refused.
  lbcs_fifo #(
    .WIDTH (LBCS_DATA_W),
    .DEPTH (LBCS_FIFO_DEPTH)
  ) u_fifo (
    .clock     (clock),
    .srst      (srst),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   (ad_s2_reg),
    .out_valid (rd_valid),
    .out_ready (rd_ready),
    .out_data  (rd_data)
  );

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);

  chk_status_code: assert property (ale |-> bus_cycle_status == status_reg) // R1 R11
    else $error("status code differs from the started cycle");
  chk_ale_pulse: assert property ($rose(ale) |=> !ale ##1 !ale) // R2
    else $error("address latch pulse longer than one clock");
  chk_upper_word: assert property (ale && !NARROW_BUS && word_reg && !refresh_reg
                                   |-> !upper_byte_enable_n) // R3
    else $error("upper byte not enabled on a word transfer");
  chk_refresh_code: assert property (ale && !NARROW_BUS && refresh_reg
                                     |-> ad_out[0] && upper_byte_enable_n) // R4
    else $error("refresh encoding wrong on the wide bus");
  chk_narrow_refresh: assert property (ale && NARROW_BUS
                                       |-> upper_byte_enable_n == !refresh_reg) // R5
    else $error("refresh indicator wrong on the narrow bus");
  chk_read_release: assert property (!rd_strobe_n |-> !ad_oe && !transceiver_enable_n) // R6
    else $error("bus driven during a read strobe");
  chk_write_data: assert property (!wr_strobe_n |-> ad_oe && ad_out == wdata_reg) // R7
    else $error("write data not held during the write strobe");
  chk_wait_ready: assert property (state_reg == LBCS_T3 && period_end && !ready_s2_reg
                                   && !nowait_reg |=> state_reg == LBCS_T3 [*2]) // R8 R15
    else $error("wait period not inserted for an inactive ready");
  chk_nowait_end: assert property (state_reg == LBCS_T3 && period_end && nowait_reg
                                   |=> state_reg == LBCS_T4) // R9
    else $error("cycle ignoring ready did not end");
  chk_xcvr_addr: assert property (ale |-> transceiver_enable_n) // R10
    else $error("transceiver enabled in the address phase");
  chk_ref_toggle: assert property (output_timing_reference |=> !output_timing_reference
                                   ##1 output_timing_reference) // R12
    else $error("output timing reference not at half rate");
  chk_hold_float: assert property (bus_release_grant |-> !ad_oe && !ctrl_oe) // R13
    else $error("bus not floated during hold grant");
  chk_strobe_order: assert property ($fell(rd_strobe_n) || $fell(wr_strobe_n)
                                     |-> $past(ale, 2)) // R14
    else $error("strobe not preceded by the address phase");
  chk_idle_after: assert property (state_reg == LBCS_T4 |-> bus_cycle_status == LBCS_ST_IDLE) // R14
    else $error("status not idle after the cycle");

  // Ready is acted on only at a period end, so a ready pulse inside a period cannot end it early.
  chk_midperiod_hold: assert property ( // R15
    state_reg == LBCS_T3 && !period_end |=> state_reg == LBCS_T3)
    else $error("wait phase left in the middle of a period");
  chk_status_held: assert property ( // R11 R14
    !rd_strobe_n || !wr_strobe_n |-> bus_cycle_status == status_reg)
    else $error("status code changed during the data phase");

  cov_read_cycle: cover property (push);
  cov_write_wait: cover property (!wr_strobe_n && state_reg == LBCS_T3 ##2 state_reg == LBCS_T3);
  cov_hold_grant: cover property ($rose(bus_release_grant));
  cov_refresh: cover property (ale && refresh_reg);
  cov_narrow_refresh: cover property (ale && NARROW_BUS && refresh_reg);
endmodule

// ===== lbcs_mem_model.sv
// Behavioural memory and I/O device that answers the local bus cycles.
`timescale 1ns/10ps
module lbcs_mem_model (
  // Clock.
  input  wire logic        clock,
  // Bus pins from the block.
  input  wire logic        ale,
  input  wire logic [3:0]  addr_hi,
  input  wire logic [15:0] ad_out,
  input  wire logic        rd_strobe_n,
  input  wire logic        wr_strobe_n,
  input  wire logic        upper_byte_enable_n,
  // Wait periods to insert before ready.
  input  wire logic [3:0]  wait_cnt,
  // Bus pins back to the block.
  output logic [15:0]      ad_in,
  output logic             ready_pin
);
  logic [15:0] mem [0:255];
  logic [19:0] addr_reg;
  logic [4:0]  cnt_reg;
  logic [15:0] last_reg;
  wire  [7:0]  idx = addr_reg[8:1];

  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 16'h0000;
    end
    addr_reg = 20'h00000;
    cnt_reg  = 5'h00;
    last_reg = 16'h0000;
  end

  always @(posedge clock) begin
    if (ale) begin
      addr_reg <= {addr_hi, ad_out};
    end
    cnt_reg <= (!rd_strobe_n || !wr_strobe_n) ? cnt_reg + 5'h01 : 5'h00;
    if (!wr_strobe_n) begin
      if (!addr_reg[0]) begin
        mem[idx][7:0] <= ad_out[7:0];
      end
      if (!upper_byte_enable_n) begin
        mem[idx][15:8] <= ad_out[15:8];
      end
    end
    if (!rd_strobe_n) begin
      last_reg <= mem[idx];
    end
  end

  // A released bus shows the inverse of its last value, so stale data cannot pass.
  assign ad_in = !rd_strobe_n ? mem[idx] : ~last_reg;
  // Ready is held off for two clocks per wait period counted from the strobe.
  assign ready_pin = (cnt_reg >= {wait_cnt, 1'b0});
endmodule

// ===== tb_top.sv
// Self-checking testbench of the local bus cycle sequencer.
`timescale 1ns/10ps
module tb_top;
  import lbcs_pkg::*;

  typedef struct {
    logic [2:0] st; logic [19:0] addr; logic [15:0] wd; logic word, rf, nw;
    logic [3:0] w; logic lsb, ube; logic [15:0] rdx;
  } lbcs_row_t;

  logic clock = 1'b0, srst = 1'b1, req_valid = 1'b0, req_word = 1'b0, req_refresh = 1'b0;
  logic req_no_wait = 1'b0, rd_ready = 1'b0, hold_request = 1'b0;
  logic [2:0]  req_status = 3'h7;
  logic [19:0] req_addr = 20'h00000;
  logic [15:0] req_wdata = 16'h0000;
  logic [3:0]  wait_cnt = 4'h0;
  logic req_ready, rd_valid, output_timing_reference, ale, upper_byte_enable_n, rd_strobe_n;
  logic wr_strobe_n, transceiver_enable_n, ad_oe, ctrl_oe, bus_release_grant, ready_pin;
  logic [15:0] rd_data, ad_out, ad_in;
  logic [2:0]  bus_cycle_status, st_cap = 3'h0;
  logic [3:0]  addr_hi;
  logic [19:0] adr_cap = 20'h00000;
  logic        ube_cap = 1'b0, xcvr_bad = 1'b0, nube_cap = 1'b1, hit, prev;
  logic        narrow_ube_n;
  int n_errors = 0, total_checks = 0, cyc = 0, ale_n = 0, rd_lo = 0, wr_lo = 0, xcvr_lo = 0;
  int rd0, wr0, xcvr0, slo;
  lbcs_row_t r;
  lbcs_row_t rows [11] = '{
    '{3'h6, 20'h00010, 16'h1234, 1, 0, 0, 0, 0, 0, 16'h0000},
    '{3'h6, 20'h00020, 16'habab, 0, 0, 0, 1, 0, 1, 16'h0000},
    '{3'h2, 20'h00021, 16'hcdcd, 0, 0, 0, 2, 1, 0, 16'h0000},
    '{3'h5, 20'h00010, 16'h0000, 1, 0, 0, 1, 0, 0, 16'h1234},
    '{3'h1, 20'h00020, 16'h0000, 1, 0, 0, 0, 0, 0, 16'hcdab},
    '{3'h4, 20'h00020, 16'h0000, 1, 0, 0, 2, 0, 0, 16'hcdab},
    '{3'h0, 20'h00010, 16'h0000, 1, 0, 0, 0, 0, 0, 16'h1234},
    '{3'h6, 20'h00051, 16'h7777, 1, 0, 0, 0, 0, 0, 16'h0000},
    '{3'h5, 20'h00050, 16'h0000, 1, 0, 1, 3, 0, 0, 16'h7777},
    '{3'h5, 20'h00031, 16'h0000, 1, 1, 0, 0, 1, 1, 16'h0000},
    '{3'h3, 20'h00000, 16'h0000, 1, 0, 0, 0, 0, 0, 16'h0000}};

  always #10 clock = ~clock;

  lbcs_bus_master dut (
    .clock(clock), .srst(srst), .req_valid(req_valid), .req_ready(req_ready),
    .req_status(req_status), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_word(req_word), .req_refresh(req_refresh), .req_no_wait(req_no_wait),
    .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data),
    .output_timing_reference(output_timing_reference), .bus_cycle_status(bus_cycle_status),
    .ale(ale), .upper_byte_enable_n(upper_byte_enable_n), .rd_strobe_n(rd_strobe_n),
    .wr_strobe_n(wr_strobe_n), .transceiver_enable_n(transceiver_enable_n),
    .addr_hi(addr_hi), .ad_out(ad_out), .ad_oe(ad_oe), .ad_in(ad_in), .ctrl_oe(ctrl_oe),
    .ready_pin(ready_pin), .hold_request(hold_request),
    .bus_release_grant(bus_release_grant));

  // The narrow variant sees the same bus and differs only on the upper enable pin.
  lbcs_bus_master #(.NARROW_BUS(1'b1)) dut_narrow (
    .clock(clock), .srst(srst), .req_valid(req_valid), .req_ready(),
    .req_status(req_status), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_word(req_word), .req_refresh(req_refresh), .req_no_wait(req_no_wait),
    .rd_valid(), .rd_ready(rd_ready), .rd_data(), .output_timing_reference(),
    .bus_cycle_status(), .ale(), .upper_byte_enable_n(narrow_ube_n), .rd_strobe_n(),
    .wr_strobe_n(), .transceiver_enable_n(), .addr_hi(), .ad_out(), .ad_oe(),
    .ad_in(ad_in), .ctrl_oe(), .ready_pin(ready_pin), .hold_request(hold_request),
    .bus_release_grant());

  lbcs_mem_model mem (
    .clock(clock), .ale(ale), .addr_hi(addr_hi), .ad_out(ad_out),
    .rd_strobe_n(rd_strobe_n), .wr_strobe_n(wr_strobe_n),
    .upper_byte_enable_n(upper_byte_enable_n), .wait_cnt(wait_cnt),
    .ad_in(ad_in), .ready_pin(ready_pin));

  // Bus watcher: address phase snapshot and strobe and enable low counts.
  always @(posedge clock) begin
    if (ale === 1'b1) begin
      ale_n   <= ale_n + 1;
      st_cap  <= bus_cycle_status;
      adr_cap <= {addr_hi, ad_out};
      ube_cap <= upper_byte_enable_n;
      nube_cap <= narrow_ube_n;
      xcvr_bad <= xcvr_bad | (transceiver_enable_n !== 1'b1);
    end
    rd_lo   <= rd_lo + int'(rd_strobe_n === 1'b0);
    wr_lo   <= wr_lo + int'(wr_strobe_n === 1'b0);
    xcvr_lo <= xcvr_lo + int'(transceiver_enable_n === 1'b0);
  end

  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      n_errors++;
      end_sim();
    end
  end

  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic run_cycle(input lbcs_row_t c);
    int k, n0;
    n0 = ale_n;
    @(posedge clock);
    {req_status, req_addr, req_wdata} <= {c.st, c.addr, c.wd};
    {req_word, req_refresh, req_no_wait, wait_cnt} <= {c.word, c.rf, c.nw, c.w};
    req_valid <= 1'b1;
    k = 0;
    do begin
      @(negedge clock);
      k++;
    end while (req_ready !== 1'b1 && k < 100);
    @(posedge clock);
    req_valid <= 1'b0;
    k = 0;
    while (!(ale_n != n0 && bus_cycle_status === 3'h7 && rd_strobe_n === 1'b1
             && wr_strobe_n === 1'b1) && k < 100) begin
      @(negedge clock);
      k++;
    end
    chk(20'(k < 100), 20'h1);
    repeat (3) @(negedge clock);
  endtask

  task automatic pop(input logic [15:0] exp);
    int k;
    k = 0;
    @(negedge clock);
    while (rd_valid !== 1'b1 && k < 50) begin
      @(negedge clock);
      k++;
    end
    chk(20'(rd_data), 20'(exp));
    @(posedge clock);
    rd_ready <= 1'b1;
    @(posedge clock);
    rd_ready <= 1'b0;
  endtask

  task automatic refused(output logic seen);
    seen = 1'b0;
    @(posedge clock);
    req_valid <= 1'b1;
    repeat (30) begin
      @(negedge clock);
      seen = seen | (req_ready !== 1'b0);
    end
    @(posedge clock);
    req_valid <= 1'b0;
  endtask

  initial begin
    repeat (8) @(posedge clock);
    @(negedge clock);
    chk(20'({bus_cycle_status, ale, rd_strobe_n, wr_strobe_n, transceiver_enable_n,
             upper_byte_enable_n, ad_oe, ctrl_oe, bus_release_grant, rd_valid}), 20'h00ef4);
    @(posedge clock);
    srst <= 1'b0;
    @(negedge clock);
    prev = output_timing_reference;
    repeat (4) begin
      @(negedge clock);
      chk(20'(output_timing_reference), 20'(!prev));
      prev = output_timing_reference;
    end
    $display("test reset done");
    for (int i = 0; i < 11; i++) begin
      r = rows[i];
      {rd0, wr0, xcvr0} = {rd_lo, wr_lo, xcvr_lo};
      run_cycle(r);
      slo = (r.st == 3'h3) ? 0 : (r.nw ? 4 : 4 + 2 * int'(r.w));
      chk(20'(st_cap), 20'(r.st));
      if (r.st != 3'h3) begin
        chk(adr_cap, {r.addr[19:1], r.lsb});
        chk(20'(ube_cap), 20'(r.ube));
        chk(20'(nube_cap), 20'(!r.rf));
      end
      hit = r.st inside {3'h0, 3'h1, 3'h4, 3'h5};
      chk(20'(hit ? rd_lo - rd0 : wr_lo - wr0), 20'(slo));
      chk(20'(hit ? wr_lo - wr0 : rd_lo - rd0), 20'h0);
      chk(20'(xcvr_lo - xcvr0), 20'(slo));
      if (hit) pop(r.rdx);
      $display("test row %0d done", i);
    end
    chk(20'(xcvr_bad), 20'h0);
    @(posedge clock);
    hold_request <= 1'b1;
    repeat (10) @(negedge clock);
    chk(20'({bus_release_grant, ctrl_oe, ad_oe}), 20'h4);
    refused(hit);
    chk(20'(hit), 20'h0);
    @(posedge clock);
    hold_request <= 1'b0;
    repeat (10) @(negedge clock);
    chk(20'({bus_release_grant, ctrl_oe}), 20'h1);
    $display("test hold done");
    r = rows[3];
    r.nw = 1'b1;
    repeat (32) run_cycle(r);
    refused(hit);
    chk(20'({hit, rd_valid}), 20'h1);
    repeat (32) pop(16'h1234);
    repeat (3) @(negedge clock);
    chk(20'(rd_valid), 20'h0);
    $display("test fifo done");
    end_sim();
  end
endmodule
